// File: hdl/tsr_pkg.sv
// Constants and types shared by the temperature result and configuration logic
package tsr_pkg;

  // ----------------------------------------------------------------
  // Register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_TEMP_OFS = 8'h00;
  localparam logic [7:0] REG_CFG_OFS = 8'h01;
  localparam logic [15:0] TEMP_RST_VAL = 16'h8000;
  localparam logic [15:0] CFG_RST_VAL = 16'h0220;
  localparam logic [15:0] CFG_WR_MASK = 16'h0FFC;
  localparam logic [15:0] RDATA_RST_VAL = 16'h0000;

  // One result step in millidegrees Celsius
  localparam real TEMP_LSB_MILLIDEG = 7.8125;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int STBY_UNIT_US = 125000;
  localparam int STBY_UNIT_CYC = STBY_UNIT_US * CLK_MHZ;
  localparam int CNT_W = 32;

  // ----------------------------------------------------------------
  // Mode codes and averaging shifts
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_FREE_RUNNING = 2'h0;
  localparam logic [1:0] MODE_POWERDOWN = 2'h1;
  localparam logic [1:0] MODE_ALIAS = 2'h2;
  localparam logic [1:0] MODE_SINGLE_SHOT = 2'h3;
  localparam int SHIFT_W = 3;
  localparam logic [2:0] AVG_SHIFT_1 = 3'h0;
  localparam logic [2:0] AVG_SHIFT_8 = 3'h3;
  localparam logic [2:0] AVG_SHIFT_32 = 3'h5;
  localparam logic [2:0] AVG_SHIFT_64 = 3'h6;
  localparam logic [6:0] SMP_CNT_ONE = 7'h01;

  // ----------------------------------------------------------------
  // Configuration register layout, bit 15 first
  // ----------------------------------------------------------------
  typedef struct packed {
    logic high_flag;
    logic low_flag;
    logic ready_flag;
    logic nv_busy;
    logic [1:0] conversion_mode_sel;
    logic [2:0] cycle_period_sel;
    logic [1:0] averaging_sel;
    logic comparator_style_sel;
    logic out_pin_sense;
    logic pin_source_sel;
    logic [1:0] unused;
  } tsr_cfg_type;

  typedef enum logic [1:0] {
    ST_LOAD = 2'h0,
    ST_IDLE = 2'h1,
    ST_CONV = 2'h3,
    ST_STBY = 2'h2
  } tsr_state_type;

endpackage

// File: hdl/tsr_avg.sv
// Block averager: sums a set of samples, then divides by shifting
`timescale 1ns/1ps
module tsr_avg import tsr_pkg::*; #(
  parameter int DATA_W = 16,
  parameter int ACC_W = 22
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Sample stream
  input wire logic smp_valid,
  input wire logic smp_last,
  input wire logic [DATA_W-1:0] smp_data,
  input wire logic [SHIFT_W-1:0] shift,
  // Averaged result
  output logic avg_valid_ff,
  output logic [DATA_W-1:0] avg_data_ff
);

  logic signed [ACC_W-1:0] acc_ff;
  logic signed [ACC_W-1:0] sum;
  logic signed [ACC_W-1:0] quot;

  // Sign extension keeps negative temperatures correct in the sum
  assign sum = acc_ff + ACC_W'($signed(smp_data));
  assign quot = sum >>> shift;

  // ----------------------------------------------------------------
  // Accumulate
  // ----------------------------------------------------------------
  // RQ11 block average
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      acc_ff <= '0;
    end else if (smp_valid) begin
      acc_ff <= smp_last ? '0 : sum;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      avg_valid_ff <= 1'b0;
      avg_data_ff <= '0;
    end else begin
      avg_valid_ff <= smp_valid && smp_last;
      if (smp_valid && smp_last) begin
        avg_data_ff <= quot[DATA_W-1:0];
      end
    end
  end

endmodule // tsr_avg

// File: hdl/tsr_regs.sv
// Temperature result and configuration registers with conversion sequencing
//
// Summary of operation
// RQ1 - Result register is 16-bit read-only, holds latest completed conversion.
// RQ2 - Result is two's complement, one step is 7.8125 millidegrees.
// RQ3 - After reset the result reads 8000h until the first conversion.
// RQ4 - Alert style: bit 15 sets above high limit, clears on config read.
// RQ5 - Therm style: bit 15 sets above limit, clears below hysteresis only.
// RQ6 - Alert style: bit 14 sets below low limit, clears on read; therm reads 0.
// RQ7 - Bit 13 sets on result update, clears on result or config read.
// RQ8 - Bit 12 reads 1 while storage loads or programs.
// RQ9 - Mode 00 continuous, 01 shutdown, 11 single shot; 10 acts as 00.
// RQ10 - Bits 9:7 choose standby between continuous conversions, reset 100.
// RQ11 - Bits 6:5 choose block average sample count, reset 01.
// RQ12 - Bit 3 set makes event pin active high, clear active low.
// RQ13 - Bit 2 set routes ready flag to pin, clear routes limit flags.
// RQ14 - Mode high bit never restored from storage.
// RQ15 - Config reset value comes from storage, factory image 0220.
// RQ16 - Storage cells supply reset values; the host may reprogram them.
// RQ17 - Config bits 1:0 ignore writes and read zero.
`timescale 1ns/1ps
module tsr_regs import tsr_pkg::*; #(
  parameter int STBY_UNIT = STBY_UNIT_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Register access port
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata_ff,
  // Limits and stored configuration image
  input wire logic [15:0] high_limit,
  input wire logic [15:0] low_limit,
  input wire logic [15:0] nv_cfg_image,
  input wire logic nv_busy,
  // Converter front end
  output logic adc_start_ff,
  input wire logic adc_done,
  input wire logic [15:0] adc_sample,
  // Event pin
  output logic event_pin_ff
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  tsr_state_type state_ff;
  tsr_state_type nxt_state;
  tsr_cfg_type cfg_ff;
  tsr_cfg_type cfg_view;
  tsr_cfg_type wr_view;
  tsr_cfg_type nv_view;
  logic [15:0] temp_ff;
  logic hi_ff;
  logic lo_ff;
  logic dr_ff;
  logic [CNT_W-1:0] stby_cnt_ff;
  logic [CNT_W-1:0] stby_len;
  logic [6:0] smp_cnt_ff;
  logic [SHIFT_W-1:0] shift_ff;
  logic [SHIFT_W-1:0] nxt_shift;
  logic rd_temp;
  logic rd_cfg;
  logic wr_cfg;
  logic style;
  logic [1:0] mode;
  logic run_req;
  logic conv_start;
  logic smp_valid;
  logic smp_last;
  logic upd;
  logic [15:0] avg_data;
  logic avg_gt_hi;
  logic avg_lt_lo;
  logic pin_active;
  logic pin_level;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign rd_temp = reg_rd && (reg_addr == REG_TEMP_OFS);
  assign rd_cfg = reg_rd && (reg_addr == REG_CFG_OFS);
  assign wr_cfg = reg_wr && (reg_addr == REG_CFG_OFS);
  assign wr_view = tsr_cfg_type'(reg_wdata & CFG_WR_MASK);
  assign nv_view = tsr_cfg_type'(nv_cfg_image & CFG_WR_MASK);
  assign style = cfg_ff.comparator_style_sel;
  assign mode = cfg_ff.conversion_mode_sel;
  assign run_req = (mode == MODE_FREE_RUNNING) || (mode == MODE_SINGLE_SHOT);
  assign smp_valid = (state_ff == ST_CONV) && adc_done;
  assign smp_last = (smp_cnt_ff == (SMP_CNT_ONE << shift_ff) - SMP_CNT_ONE);
  // RQ2 signed compare
  assign avg_gt_hi = $signed(avg_data) > $signed(high_limit);
  assign avg_lt_lo = $signed(avg_data) < $signed(low_limit);

  // ----------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------
  // The stored image is taken once storage reports ready after release
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      cfg_ff <= tsr_cfg_type'(CFG_RST_VAL);
    end else if (state_ff == ST_LOAD) begin
      if (!nv_busy) begin
        // RQ15 RQ16 load stored image
        cfg_ff <= nv_view;
        // RQ14 mode high bit
        cfg_ff.conversion_mode_sel[1] <= 1'b0;
      end
    end else if (wr_cfg) begin
      // RQ17 unused bits masked
      cfg_ff <= wr_view;
      // RQ9 alias code folds
      if (wr_view.conversion_mode_sel == MODE_ALIAS) begin
        cfg_ff.conversion_mode_sel <= MODE_FREE_RUNNING;
      end
    end else if (upd && (mode == MODE_SINGLE_SHOT)) begin
      cfg_ff.conversion_mode_sel <= MODE_POWERDOWN;
    end
  end

  always_comb begin
    cfg_view = cfg_ff;
    cfg_view.high_flag = hi_ff;
    // RQ6 therm reads zero
    cfg_view.low_flag = lo_ff && !style;
    cfg_view.ready_flag = dr_ff;
    // RQ8 busy while loading
    cfg_view.nv_busy = nv_busy || (state_ff == ST_LOAD);
    cfg_view.unused = 2'h0;
  end

  // ----------------------------------------------------------------
  // Result register
  // ----------------------------------------------------------------
  // RQ1 RQ3 result update
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      temp_ff <= TEMP_RST_VAL;
    end else if (upd) begin
      temp_ff <= avg_data;
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // A new result wins over a read that clears in the same cycle
  // RQ4 RQ5 high flag
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      hi_ff <= 1'b0;
    end else if (upd && avg_gt_hi) begin
      hi_ff <= 1'b1;
    end else if (style ? (upd && avg_lt_lo) : rd_cfg) begin
      hi_ff <= 1'b0;
    end
  end

  // RQ6 low flag
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      lo_ff <= 1'b0;
    end else if (style) begin
      lo_ff <= 1'b0;
    end else if (upd && avg_lt_lo) begin
      lo_ff <= 1'b1;
    end else if (rd_cfg) begin
      lo_ff <= 1'b0;
    end
  end

  // RQ7 ready flag
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      dr_ff <= 1'b0;
    end else if (upd) begin
      dr_ff <= 1'b1;
    end else if (rd_cfg || rd_temp) begin
      dr_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      reg_rdata_ff <= RDATA_RST_VAL;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_TEMP_OFS: begin
          reg_rdata_ff <= temp_ff;
        end
        REG_CFG_OFS: begin
          reg_rdata_ff <= cfg_view;
        end
        default: begin
          reg_rdata_ff <= RDATA_RST_VAL;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_LOAD: begin
        if (!nv_busy) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (run_req) begin
          nxt_state = ST_CONV;
        end
      end
      ST_CONV: begin
        if (upd) begin
          nxt_state = (mode == MODE_FREE_RUNNING) ? ST_STBY : ST_IDLE;
        end
      end
      ST_STBY: begin
        if (mode == MODE_SINGLE_SHOT) begin
          nxt_state = ST_CONV;
        end else if (mode == MODE_POWERDOWN) begin
          nxt_state = ST_IDLE;
        end else if (stby_cnt_ff == '0) begin
          nxt_state = ST_CONV;
        end
      end
      default: begin
        nxt_state = ST_LOAD;
      end
    endcase
  end

  assign conv_start = (state_ff != ST_CONV) && (nxt_state == ST_CONV);

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_ff <= ST_LOAD;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // RQ10 standby length
  always_comb begin
    if (cfg_ff.cycle_period_sel == 3'h0) begin
      stby_len = '0;
    end else begin
      stby_len = CNT_W'(STBY_UNIT) << (cfg_ff.cycle_period_sel - 3'h1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      stby_cnt_ff <= '0;
    end else if (upd) begin
      stby_cnt_ff <= stby_len;
    end else if ((state_ff == ST_STBY) && (stby_cnt_ff != '0)) begin
      stby_cnt_ff <= stby_cnt_ff - CNT_W'(1);
    end
  end

  // RQ11 sample count
  always_comb begin
    case (cfg_ff.averaging_sel)
      2'h0: nxt_shift = AVG_SHIFT_1;
      2'h1: nxt_shift = AVG_SHIFT_8;
      2'h2: nxt_shift = AVG_SHIFT_32;
      default: nxt_shift = AVG_SHIFT_64;
    endcase
  end

  // Count is latched per block so a mid-block write cannot skew the divide
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      shift_ff <= AVG_SHIFT_1;
      smp_cnt_ff <= '0;
    end else if (conv_start) begin
      shift_ff <= nxt_shift;
      smp_cnt_ff <= '0;
    end else if (smp_valid) begin
      smp_cnt_ff <= smp_last ? 7'h00 : smp_cnt_ff + SMP_CNT_ONE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      adc_start_ff <= 1'b0;
    end else begin
      adc_start_ff <= conv_start || (smp_valid && !smp_last);
    end
  end

  tsr_avg #(
    .DATA_W(16),
    .ACC_W(22)
  ) u_avg (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .smp_valid(smp_valid),
    .smp_last(smp_last),
    .smp_data(adc_sample),
    .shift(shift_ff),
    .avg_valid_ff(upd),
    .avg_data_ff(avg_data)
  );

  // ----------------------------------------------------------------
  // Event pin
  // ----------------------------------------------------------------
  // RQ13 pin source
  assign pin_active = cfg_ff.pin_source_sel ? dr_ff : (hi_ff || (lo_ff && !style));
  // RQ12 pin polarity
  assign pin_level = cfg_ff.out_pin_sense ? pin_active : !pin_active;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      event_pin_ff <= 1'b1;
    end else begin
      event_pin_ff <= pin_level;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_temp_hold;
    @(posedge sys_clk) disable iff (!rst_b) !upd |=> $stable(temp_ff);
  endproperty
  a_temp_hold: assert property (p_temp_hold) else $error("result changed without update"); // RQ1

  property p_temp_reset;
    @(posedge sys_clk) disable iff (!rst_b) $past(!rst_b) |-> (temp_ff == TEMP_RST_VAL) ##1 (temp_ff == TEMP_RST_VAL);
  endproperty
  a_temp_reset: assert property (p_temp_reset) else $error("result not at reset value"); // RQ3

  property p_high_alert;
    @(posedge sys_clk) disable iff (!rst_b) (upd && !style && avg_gt_hi) |=> hi_ff ##1 (hi_ff || $past(rd_cfg));
  endproperty
  a_high_alert: assert property (p_high_alert) else $error("high flag not held"); // RQ4

  property p_therm_keep;
    @(posedge sys_clk) disable iff (!rst_b) (style && hi_ff && !upd && !wr_cfg) |=> hi_ff;
  endproperty
  a_therm_keep: assert property (p_therm_keep) else $error("therm flag cleared without result"); // RQ5

  property p_low_therm;
    @(posedge sys_clk) disable iff (!rst_b) (rd_cfg && style) |=> !reg_rdata_ff[14];
  endproperty
  a_low_therm: assert property (p_low_therm) else $error("low flag visible in therm style"); // RQ6

  property p_ready;
    @(posedge sys_clk) disable iff (!rst_b) upd |=> dr_ff ##1 ((dr_ff != $past(rd_cfg || rd_temp)) || $past(upd));
  endproperty
  a_ready: assert property (p_ready) else $error("ready flag wrong after update"); // RQ7

  property p_mode_alias;
    @(posedge sys_clk) disable iff (!rst_b) rd_cfg |=> (reg_rdata_ff[11:10] != MODE_ALIAS) && (reg_rdata_ff[1:0] == 2'h0);
  endproperty
  a_mode_alias: assert property (p_mode_alias) else $error("alias mode or unused bits read back"); // RQ9

  property p_load_mode;
    @(posedge sys_clk) disable iff (!rst_b) (state_ff == ST_LOAD && !nv_busy) |=> !mode[1] ##1 (state_ff != ST_LOAD);
  endproperty
  a_load_mode: assert property (p_load_mode) else $error("mode high bit restored"); // RQ14

  property p_pin;
    @(posedge sys_clk) disable iff (!rst_b) (cfg_ff.pin_source_sel && dr_ff) |=> (event_pin_ff == $past(cfg_ff.out_pin_sense));
  endproperty
  a_pin: assert property (p_pin) else $error("event pin level wrong"); // RQ12 RQ13

endmodule // tsr_regs

// File: testbench/tsr_host_model.sv
// Host controller model that drives the register access port
`timescale 1ns/1ps
module tsr_host_model (
  // Clock
  input wire logic sys_clk,
  // Register access port
  output logic [7:0] reg_addr,
  output logic reg_rd,
  output logic reg_wr,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata_ff
);
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  initial begin
    reg_addr = 8'h00;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
  end

  // Released lines show the inverse so a stale value never looks valid
  task automatic wr(input logic [7:0] addr, input logic [15:0] data);
    @(negedge sys_clk);
    reg_addr = addr;
    reg_wdata = data;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    reg_addr = ~addr;
    reg_wdata = ~data;
  endtask

  // Data is taken one edge after the strobe, where it is settled
  task automatic rd(input logic [7:0] addr, output logic [15:0] data);
    @(negedge sys_clk);
    reg_addr = addr;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    reg_addr = ~addr;
    @(negedge sys_clk);
    data = reg_rdata_ff;
  endtask
endmodule // tsr_host_model

// File: testbench/tsr_regs_tb.sv
// Self-checking bench for the result and configuration registers
`timescale 1ns/1ps
module tsr_regs_tb import tsr_pkg::*;;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int STBY = 20;
  localparam int LAT = 3;
  // Long enough for a 64-sample block at this responder latency
  localparam int WAIT_MAX = 800;
  typedef struct packed {
    logic [7:0] wa;
    logic [15:0] wd;
    logic [7:0] ra;
    logic [15:0] ex;
    logic pin;
  } tsr_row_type;
  tsr_row_type rows [6] = '{'{8'h01, 16'hF403, 8'h01, 16'h0400, 1'b1}, '{8'h01, 16'h05FC, 8'h01, 16'h05FC, 1'b0},
    '{8'h00, 16'h1234, 8'h00, 16'h8000, 1'b0}, '{8'h05, 16'h1234, 8'h01, 16'h05FC, 1'b0},
    '{8'h01, 16'h0408, 8'h05, 16'h0000, 1'b0}, '{8'h01, 16'h0404, 8'h01, 16'h0404, 1'b1}};
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic nv_busy = 1'b1;
  logic adc_done = 1'b0;
  logic reg_rd, reg_wr, adc_start_ff, event_pin_ff;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata_ff, rd_val;
  logic [15:0] high_limit = 16'h0100;
  logic [15:0] low_limit = 16'h0000;
  logic [15:0] nv_cfg_image = 16'h0E27;
  logic [15:0] adc_sample = 16'h0000;
  logic [15:0] smp_def = 16'h0000;
  logic [15:0] smp_q [$];
  int miscompares = 0;
  int num_checks = 0;
  int cnt = -1;
  int cyc = 0;
  int last_st = 0;
  int gap = 0;
  int dones = 0;

  tsr_regs #(.STBY_UNIT(STBY)) dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .high_limit(high_limit),
    .low_limit(low_limit), .nv_cfg_image(nv_cfg_image), .nv_busy(nv_busy), .adc_start_ff(adc_start_ff),
    .adc_done(adc_done), .adc_sample(adc_sample), .event_pin_ff(event_pin_ff));
  tsr_host_model host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff));

  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;

  // ----------------------------------------------------------------
  // Converter responder: one sample outstanding, fixed latency
  // ----------------------------------------------------------------
  always @(negedge sys_clk) begin
    adc_done <= (cnt == 0);
    adc_sample <= (cnt == 0) ? ((smp_q.size() > 0) ? smp_q.pop_front() : smp_def) : ~adc_sample;
    if (cnt == 0) dones <= dones + 1;
    if (adc_start_ff) begin
      cnt <= LAT;
      gap <= cyc - last_st;
      last_st <= cyc;
    end else if (cnt >= 0) cnt <= cnt - 1;
  end

  // ----------------------------------------------------------------
  // Checks and waits
  // ----------------------------------------------------------------
  task automatic chk16(input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  task automatic chk1(input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  task automatic rdchk(input logic [7:0] addr, input logic [15:0] exp);
    host.rd(addr, rd_val);
    chk16(exp, rd_val);
  endtask

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic give_up();
    miscompares++;
    $display("Error at %0t: wait ran out", $time);
    final_report();
  endtask

  task automatic wait_pin(input logic val);
    int k;
    for (k = 0; k < WAIT_MAX && event_pin_ff !== val; k++) @(negedge sys_clk);
    if (k == WAIT_MAX) give_up();
  endtask

  // Result lands two cycles after the final sample, so four is margin
  task automatic wait_conv();
    int k;
    int t;
    t = dones + 1;
    for (k = 0; k < WAIT_MAX && dones < t; k++) @(negedge sys_clk);
    if (k == WAIT_MAX) give_up();
    repeat (4) @(negedge sys_clk);
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(negedge sys_clk);
    rst_b = 1'b1;
    rdchk(8'h01, 16'h1220); // busy while loading
    rdchk(8'h00, TEMP_RST_VAL); // result before conversion
    host.wr(8'h01, 16'h0400);
    nv_busy = 1'b0;
    rdchk(8'h01, 16'h0624); // image load wins
    $display("Test load done");
    foreach (rows[r]) begin
      host.wr(rows[r].wa, rows[r].wd);
      rdchk(rows[r].ra, rows[r].ex); // access kinds
      chk1(rows[r].pin, event_pin_ff); // pin level
    end
    $display("Test table done");
    smp_q.push_back(16'h0200);
    host.wr(8'h01, 16'h0C08);
    wait_pin(1'b0);
    wait_pin(1'b1);
    rdchk(8'h01, 16'hA408); // flags after single shot
    rdchk(8'h00, 16'h0200); // latest result
    rdchk(8'h01, 16'h0408); // cleared on read
    chk1(1'b0, event_pin_ff); // pin idle again
    $display("Test alert done");
    for (int k = 0; k < 8; k++) smp_q.push_back(k[0] ? 16'hFFE8 : 16'hFFF8);
    host.wr(8'h01, 16'h0C24);
    wait_pin(1'b1);
    wait_pin(1'b0);
    rdchk(8'h01, 16'h6424); // low flag and ready
    rdchk(8'h00, 16'hFFF0); // block average
    $display("Test average done");
    // First half at the negative extreme, second half near the positive one
    for (int a = 2; a < 4; a++) begin
      for (int k = 0; k < 64; k++) smp_q.push_back((k < 32) ? 16'h8000 : 16'h7FFE);
      host.wr(8'h01, 16'h0C0C | 16'(a << 5));
      wait_pin(1'b0);
      wait_pin(1'b1);
      rdchk(8'h00, (a == 2) ? 16'h8000 : 16'hFFFF); // 32 and 64 sample blocks
      smp_q.delete();
    end
    $display("Test wide average done");
    low_limit = 16'h0080;
    smp_q.push_back(16'h0200);
    host.wr(8'h01, 16'h0C10);
    wait_pin(1'b1);
    wait_pin(1'b0);
    rdchk(8'h01, 16'hA410); // therm flag set
    rdchk(8'h01, 16'h8410); // survives read
    smp_q.push_back(16'h00C0);
    host.wr(8'h01, 16'h0C10);
    wait_conv();
    rdchk(8'h01, 16'hA410); // held above hysteresis
    smp_q.push_back(16'h0040);
    host.wr(8'h01, 16'h0C10);
    wait_conv();
    rdchk(8'h01, 16'h2410); // cleared below hysteresis
    chk1(1'b1, event_pin_ff); // active low idle
    $display("Test therm done");
    host.wr(8'h01, 16'h0800);
    host.rd(8'h01, rd_val);
    chk16(16'h0000, rd_val & 16'hDFFF); // alias reads continuous
    wait_conv();
    wait_conv();
    chk1(1'b1, gap < STBY); // no standby at zero
    host.wr(8'h01, 16'h0100);
    wait_conv();
    wait_conv();
    wait_conv();
    chk1(1'b1, gap >= 2 * STBY && gap <= 2 * STBY + 20); // standby length
    host.wr(8'h01, 16'h0400);
    nv_busy = 1'b1;
    host.rd(8'h01, rd_val);
    chk16(16'h5400, rd_val & 16'hDFFF); // busy while programming
    nv_busy = 1'b0;
    $display("Test modes done");
    rst_b = 1'b0;
    repeat (2) @(negedge sys_clk);
    rst_b = 1'b1;
    rdchk(8'h00, 16'h8000); // second reset
    rdchk(8'h01, 16'h0624); // reloaded image
    $display("Test reset done");
    final_report();
  end
endmodule // tsr_regs_tb
